/* File: include/dprc_mem_if.sv */
// memory access signals between the port control and the storage array
// assumes both ends run on the core clock
`timescale 1ns/1ps
interface dprc_mem_if;
  import dprc_pkg::*;
  logic we;
  logic [ADDR_W-1:0] waddr;
  logic [DATA_W-1:0] wdata;
  logic [LANE_N-1:0] wmask;
  logic [ADDR_W-1:0] raddr;
  logic [DATA_W-1:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output wmask, output raddr, input rdata);
  modport store (input we, input waddr, input wdata, input wmask, input raddr, output rdata);
endinterface : dprc_mem_if

/* File: include/dprc_pkg.sv */
// constants for the dual-port memory with selectable port clocking
// assumes one core clock; the two port clocks arrive as sampled edge strobes
package dprc_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int LANE_N = 4;
  localparam int LANE_BITS = 8;
  localparam int DEPTH = 256;
  localparam int AXI_AW = 8;
  localparam int CNT_W = 16;
  // register offsets
  localparam logic [AXI_AW-1:0] CFG_OFS = 8'h00;
  localparam logic [AXI_AW-1:0] STAT_OFS = 8'h04;
  // config field positions
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_TOPO_LSB = 2;
  localparam int CFG_EBS_BIT = 4;
  localparam int CFG_LEB_BIT = 5;
  localparam int CFG_OREG_BIT = 6;
  localparam int STAT_LOC_LSB = 16;
  localparam logic [6:0] CFG_RST = 7'h04;
  // clock modes
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_RDWR = 2'h1;
  localparam logic [1:0] MODE_INOUT = 2'h2;
  // port topologies
  localparam logic [1:0] TOPO_ONE = 2'h0;
  localparam logic [1:0] TOPO_TWO = 2'h1;
  localparam logic [1:0] TOPO_TWIN = 2'h2;
  localparam logic [1:0] TOPO_ROM = 2'h3;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [LANE_N-1:0] MASK_ALL = 4'hF;
  typedef enum logic [1:0] {W_IDLE = 2'b01, W_RESP = 2'b10} dprc_wst_t;
  typedef enum logic [1:0] {R_IDLE = 2'b01, R_DATA = 2'b10} dprc_rst_t;
endpackage : dprc_pkg

/* File: tb/dprc_fabric.sv */
// user-logic model that drives the memory ports of the dual-port block
// assumes its tasks are entered just after a rising core clock edge
`timescale 1ns/1ps
module dprc_fabric (
  input wire logic core_clk_i,
  output logic input_side_clock_o,
  output logic output_side_clock_o,
  output logic input_clock_gate_o,
  output logic output_clock_gate_o,
  output logic [dprc_pkg::DATA_W-1:0] write_word_o,
  output logic [dprc_pkg::ADDR_W-1:0] write_location_o,
  output logic write_strobe_o,
  output logic [dprc_pkg::LANE_N-1:0] lane_mask_o,
  output logic [dprc_pkg::ADDR_W-1:0] read_location_o,
  output logic read_gate_o,
  output logic [dprc_pkg::ADDR_W-1:0] location_a_o,
  output logic [dprc_pkg::DATA_W-1:0] write_word_a_o,
  output logic write_strobe_a_o,
  output logic [dprc_pkg::LANE_N-1:0] lane_mask_a_o
);
  import dprc_pkg::*;
  // ****************************************
  // port drive
  // ****************************************
  // the unused write side carries inverted junk so a wrong source shows
  task automatic put(input logic a, input logic [ADDR_W-1:0] l, input logic [DATA_W-1:0] d,
      input logic [LANE_N-1:0] m, input logic we, input logic [ADDR_W-1:0] rl, input logic rg);
    write_location_o <= a ? ~l : l;
    write_word_o <= a ? ~d : d;
    lane_mask_o <= a ? ~m : m;
    write_strobe_o <= !a && we;
    location_a_o <= a ? l : ~l;
    write_word_a_o <= a ? d : ~d;
    lane_mask_a_o <= a ? m : ~m;
    write_strobe_a_o <= a && we;
    read_location_o <= rl;
    read_gate_o <= rg;
  endtask : put
  // one port edge, then strobes drop and stale data is scrambled
  task automatic tick(input logic ic, input logic oc, input logic ig, input logic og);
    input_side_clock_o <= ic;
    output_side_clock_o <= oc;
    input_clock_gate_o <= ig;
    output_clock_gate_o <= og;
    @(posedge core_clk_i);
    input_side_clock_o <= 1'b0;
    output_side_clock_o <= 1'b0;
    input_clock_gate_o <= 1'b1;
    output_clock_gate_o <= 1'b1;
    write_strobe_o <= 1'b0;
    write_strobe_a_o <= 1'b0;
    write_word_o <= ~write_word_o;
    write_word_a_o <= ~write_word_a_o;
    @(posedge core_clk_i);
  endtask : tick
  initial begin
    put(1'b0, 8'h00, 32'h0, 4'h0, 1'b0, 8'h00, 1'b0);
    input_side_clock_o <= 1'b0;
    output_side_clock_o <= 1'b0;
    input_clock_gate_o <= 1'b1;
    output_clock_gate_o <= 1'b1;
  end
endmodule : dprc_fabric

/* File: tb/dprc_top_tb.sv */
// self-checking bench for the dual-port memory with port clocking modes
// assumes the fabric model drives the memory ports and this module the register bus
`timescale 1ns/1ps
module dprc_top_tb;
  import dprc_pkg::*;
  logic core_clk_i;
  logic nrst_i;
  logic [AXI_AW-1:0] awaddr;
  logic [AXI_AW-1:0] araddr;
  logic [31:0] wdata;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [31:0] rdata;
  logic [DATA_W-1:0] rr, ww, wwa;
  logic isc, osc, icg, ocg, ws, rg, wsa;
  logic [ADDR_W-1:0] wl, rl, la;
  logic [LANE_N-1:0] lm, lma;
  int failures;
  int num_checks;
  dprc_top uut (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .input_side_clock_i(isc),
    .output_side_clock_i(osc), .input_clock_gate_i(icg), .output_clock_gate_i(ocg),
    .write_word_i(ww), .write_location_i(wl), .write_strobe_i(ws), .lane_mask_i(lm),
    .read_location_i(rl), .read_gate_i(rg), .location_a_i(la), .write_word_a_i(wwa),
    .write_strobe_a_i(wsa), .lane_mask_a_i(lma), .read_result_o(rr));
  dprc_fabric f (.core_clk_i(core_clk_i), .input_side_clock_o(isc),
    .output_side_clock_o(osc), .input_clock_gate_o(icg), .output_clock_gate_o(ocg),
    .write_word_o(ww), .write_location_o(wl), .write_strobe_o(ws), .lane_mask_o(lm),
    .read_location_o(rl), .read_gate_o(rg), .location_a_o(la), .write_word_a_o(wwa),
    .write_strobe_a_o(wsa), .lane_mask_a_o(lma));
  // ****************************************
  // compare and report
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_resp
  task automatic report_and_stop();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic tmo(input int n);
    if (n >= 50) begin
      failures++;
      $display("ERROR handshake expected answer seen none");
      report_and_stop();
    end
  endtask : tmo
  // ****************************************
  // register bus master
  // ****************************************
  // readies are sampled at the falling edge, where they are settled
  task automatic axi_wr(input logic [AXI_AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic pa, pw, ta, tw;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    for (n = 0; (pa || pw) && n < 50; n++) begin
      @(negedge core_clk_i);
      ta = pa && awready;
      tw = pw && wready;
      @(posedge core_clk_i);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    tmo(n);
    for (n = 0; n < 50; n++) begin
      @(negedge core_clk_i);
      if (bvalid) break;
    end
    tmo(n);
    chk_resp("bresp", er, bresp);
    @(posedge core_clk_i);
    bready <= 1'b0;
    @(posedge core_clk_i);
  endtask : axi_wr
  task automatic axi_rd(input logic [AXI_AW-1:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge core_clk_i);
      if (arready) break;
    end
    tmo(n);
    @(posedge core_clk_i);
    arvalid <= 1'b0;
    for (n = 0; n < 50; n++) begin
      @(negedge core_clk_i);
      if (rvalid) break;
    end
    tmo(n);
    chk("rdata", ed, rdata);
    chk_resp("rresp", er, rresp);
    @(posedge core_clk_i);
    rready <= 1'b0;
    @(posedge core_clk_i);
  endtask : axi_rd
  // ****************************************
  // memory port helpers
  // ****************************************
  task automatic see(input logic [31:0] e);
    @(negedge core_clk_i);
    chk("read_result", e, rr);
    @(posedge core_clk_i);
  endtask : see
  task automatic wr(input logic a, input logic [7:0] l, input logic [31:0] d,
      input logic [3:0] m, input logic we, input logic ig);
    f.put(a, l, d, m, we, l, 1'b0);
    f.tick(1'b1, 1'b0, ig, 1'b1);
  endtask : wr
  task automatic rd(input logic a, input logic [7:0] l, input logic ic, input logic oc,
      input logic [31:0] e);
    f.put(a, l, 32'h0, 4'h0, 1'b0, l, 1'b1);
    f.tick(ic, oc, 1'b1, 1'b1);
    see(e);
  endtask : rd
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  initial begin
    failures = 0;
    num_checks = 0;
    nrst_i <= 1'b0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} <= '0;
    repeat (8) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    @(posedge core_clk_i);
    see(32'h0);
    axi_rd(CFG_OFS, {25'h0, CFG_RST}, RESP_OKAY);
    axi_rd(8'h08, 32'h0, RESP_SLVERR);
    axi_wr(STAT_OFS, 32'hFFFFFFFF, RESP_OKAY);
    axi_rd(STAT_OFS, 32'h0, RESP_OKAY);
    wr(1'b0, 8'h05, 32'hA1B2C3D4, MASK_ALL, 1'b1, 1'b1);
    see(32'h0);
    rd(1'b0, 8'h05, 1'b1, 1'b1, 32'hA1B2C3D4);
    wr(1'b0, 8'h05, 32'h11223344, 4'h5, 1'b1, 1'b1);
    rd(1'b0, 8'h05, 1'b1, 1'b1, 32'hA122C344);
    axi_rd(STAT_OFS, 32'h00050002, RESP_OKAY);
    wr(1'b0, 8'h05, 32'h55667788, MASK_ALL, 1'b0, 1'b1);
    wr(1'b0, 8'h05, 32'h55667788, MASK_ALL, 1'b1, 1'b0);
    rd(1'b0, 8'h05, 1'b1, 1'b1, 32'hA122C344);
    wr(1'b0, 8'h06, 32'h66666666, MASK_ALL, 1'b1, 1'b1);
    f.put(1'b0, 8'h06, 32'h0, 4'h0, 1'b0, 8'h06, 1'b1);
    f.tick(1'b1, 1'b1, 1'b1, 1'b0);
    see(32'hA122C344);
    rd(1'b0, 8'h06, 1'b1, 1'b1, 32'h66666666);
    axi_wr(CFG_OFS, 32'h24, RESP_OKAY);
    wr(1'b0, 8'h05, 32'h0F1E2D3C, 4'h1, 1'b1, 1'b1);
    rd(1'b0, 8'h05, 1'b1, 1'b1, 32'h0F1E2D3C);
    axi_wr(CFG_OFS, 32'h0C, RESP_OKAY);
    wr(1'b0, 8'h05, 32'h5A5A5A5A, MASK_ALL, 1'b1, 1'b1);
    rd(1'b0, 8'h05, 1'b1, 1'b1, 32'h0F1E2D3C);
    axi_wr(CFG_OFS, 32'h14, RESP_OKAY);
    wr(1'b0, 8'h07, 32'h77777777, MASK_ALL, 1'b1, 1'b1);
    f.put(1'b0, 8'h07, 32'h0, 4'h0, 1'b0, 8'h07, 1'b0);
    f.tick(1'b1, 1'b1, 1'b1, 1'b1);
    see(32'h77777777);
    axi_wr(CFG_OFS, 32'h05, RESP_OKAY);
    wr(1'b0, 8'h08, 32'h88888888, MASK_ALL, 1'b1, 1'b1);
    f.put(1'b0, 8'h08, 32'h0, 4'h0, 1'b0, 8'h08, 1'b1);
    f.tick(1'b1, 1'b0, 1'b1, 1'b1);
    see(32'h77777777);
    f.tick(1'b0, 1'b1, 1'b1, 1'b1);
    see(32'h88888888);
    f.put(1'b0, 8'h05, 32'h0, 4'h0, 1'b0, 8'h05, 1'b1);
    f.tick(1'b0, 1'b1, 1'b1, 1'b0);
    see(32'h88888888);
    axi_wr(CFG_OFS, 32'h46, RESP_OKAY);
    f.tick(1'b1, 1'b0, 1'b1, 1'b1);
    f.tick(1'b0, 1'b1, 1'b1, 1'b1);
    see(32'h0F1E2D3C);
    f.put(1'b0, 8'h07, 32'h0, 4'h0, 1'b0, 8'h07, 1'b1);
    f.tick(1'b1, 1'b0, 1'b1, 1'b1);
    see(32'h0F1E2D3C);
    f.tick(1'b0, 1'b1, 1'b1, 1'b1);
    see(32'h77777777);
    axi_wr(CFG_OFS, 32'h00, RESP_OKAY);
    wr(1'b1, 8'h09, 32'h99999999, MASK_ALL, 1'b1, 1'b1);
    rd(1'b1, 8'h09, 1'b1, 1'b1, 32'h99999999);
    axi_wr(CFG_OFS, 32'h08, RESP_OKAY);
    wr(1'b1, 8'h09, 32'hCCCCCCCC, 4'hC, 1'b1, 1'b1);
    wr(1'b1, 8'h09, 32'hEEEEEEEE, MASK_ALL, 1'b0, 1'b1);
    rd(1'b1, 8'h09, 1'b1, 1'b1, 32'hCCCC9999);
    report_and_stop();
  end
endmodule : dprc_top_tb

/* File: verilog/dprc_store.sv */
// storage array with lane-masked write and asynchronous read
// assumes the control side qualifies every write with its stage strobe
`timescale 1ns/1ps
module dprc_store (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  dprc_mem_if.store mem
);
  import dprc_pkg::*;

  logic [DATA_W-1:0] cell_r [DEPTH];
  wire [LANE_N-1:0] lane_we;

  // ****************
  // lane writes
  // ****************
  for (genvar g = 0; g < LANE_N; g++) begin : g_lane
    assign lane_we[g] = mem.we && mem.wmask[g];
  end

  // one process owns the array so each cell has a single writer
  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < LANE_N; i++) begin
      if (lane_we[i]) begin
        cell_r[mem.waddr][i*LANE_BITS +: LANE_BITS] <= mem.wdata[i*LANE_BITS +: LANE_BITS];
      end
    end
  end

  assign mem.rdata = cell_r[mem.raddr];

  // ****************
  // checks
  // ****************
  a_write_lands: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    mem.we && mem.wmask[0] |=> cell_r[$past(mem.waddr)][7:0] == $past(mem.wdata[7:0]))
    else $error("written lane did not land");
  a_lane_masked: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    mem.we && !mem.wmask[3]
    |=> cell_r[$past(mem.waddr)][31:24] == $past(cell_r[mem.waddr][31:24]))
    else $error("masked lane was changed");
endmodule : dprc_store

/* File: verilog/dprc_top.sv */
// dual-port memory with port clocking modes, port A path and a register bus
// assumes port clock strobes and user inputs are synchronous to core_clk_i
`timescale 1ns/1ps
module dprc_top (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // register bus
  input wire logic [dprc_pkg::AXI_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [dprc_pkg::AXI_AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // port clock strobes and enables
  input wire logic input_side_clock_i,
  input wire logic output_side_clock_i,
  input wire logic input_clock_gate_i,
  input wire logic output_clock_gate_i,
  // simple write and read side
  input wire logic [dprc_pkg::DATA_W-1:0] write_word_i,
  input wire logic [dprc_pkg::ADDR_W-1:0] write_location_i,
  input wire logic write_strobe_i,
  input wire logic [dprc_pkg::LANE_N-1:0] lane_mask_i,
  input wire logic [dprc_pkg::ADDR_W-1:0] read_location_i,
  input wire logic read_gate_i,
  // port A
  input wire logic [dprc_pkg::ADDR_W-1:0] location_a_i,
  input wire logic [dprc_pkg::DATA_W-1:0] write_word_a_i,
  input wire logic write_strobe_a_i,
  input wire logic [dprc_pkg::LANE_N-1:0] lane_mask_a_i,
  output logic [dprc_pkg::DATA_W-1:0] read_result_o
);
  import dprc_pkg::*;

  // ****************
  // configuration and status
  // ****************
  logic [6:0] cfg_r;
  logic [CNT_W-1:0] wr_count_r;
  logic [ADDR_W-1:0] last_loc_r;
  logic [1:0] mode;
  logic [1:0] topo;
  logic ebs;
  logic leb;
  logic oreg_en;

  assign mode = cfg_r[CFG_MODE_LSB +: 2];
  assign topo = cfg_r[CFG_TOPO_LSB +: 2];
  assign ebs = cfg_r[CFG_EBS_BIT];
  assign leb = cfg_r[CFG_LEB_BIT];
  assign oreg_en = cfg_r[CFG_OREG_BIT];

  // ****************
  // stage strobes
  // ****************
  // which pin clocks a stage: 0 = input side, 1 = output side
  function automatic logic stage_on_out(input logic [1:0] m, input logic is_read);
    // single mode reads on the shared clock but obey the output-side enable
    stage_on_out = is_read && ((m == MODE_RDWR) || (m == MODE_SINGLE));
  endfunction : stage_on_out

  logic in_go;
  logic out_go;
  logic wr_go;
  logic rd_go;
  logic q_go;

  assign in_go = input_side_clock_i && input_clock_gate_i;
  // in single mode the output pin carries the same clock, so only the input pin is watched
  assign out_go = ((mode == MODE_SINGLE) ? input_side_clock_i : output_side_clock_i)
                  && output_clock_gate_i;
  assign wr_go = stage_on_out(mode, 1'b0) ? out_go : in_go;
  assign rd_go = stage_on_out(mode, 1'b1) ? out_go : in_go;
  assign q_go = out_go;

  // ****************
  // write source
  // ****************
  dprc_mem_if mem ();

  logic port_a_sel;
  logic mask_ok;
  logic src_strobe;
  logic [ADDR_W-1:0] src_loc;
  logic [DATA_W-1:0] src_word;
  logic [LANE_N-1:0] src_mask;

  // port A drives the array in the one-port and twin topologies
  assign port_a_sel = (topo == TOPO_ONE) || (topo == TOPO_TWIN);
  assign mask_ok = !leb && (topo != TOPO_ROM);
  assign src_strobe = port_a_sel ? write_strobe_a_i : write_strobe_i;
  assign src_loc = port_a_sel ? location_a_i : write_location_i;
  assign src_word = port_a_sel ? write_word_a_i : write_word_i;
  assign src_mask = !mask_ok ? MASK_ALL : (port_a_sel ? lane_mask_a_i : lane_mask_i);

  assign mem.we = wr_go && src_strobe && (topo != TOPO_ROM);
  assign mem.waddr = src_loc;
  assign mem.wdata = src_word;
  assign mem.wmask = src_mask;
  assign mem.raddr = read_location_i;

  dprc_store u_store (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .mem(mem)
  );

  // ****************
  // read path
  // ****************
  logic rd_en;
  logic [DATA_W-1:0] rd_data_r;
  logic [DATA_W-1:0] q_out_r;

  // read gating only exists off the embedded block; elsewhere every read edge reads
  assign rd_en = ebs ? 1'b1 : read_gate_i;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rd_data_r <= '0;
    end else if (rd_go && rd_en) begin
      rd_data_r <= mem.rdata;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      q_out_r <= '0;
    end else if (q_go) begin
      q_out_r <= rd_data_r;
    end
  end

  assign read_result_o = oreg_en ? q_out_r : rd_data_r;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      wr_count_r <= '0;
      last_loc_r <= '0;
    end else if (mem.we) begin
      wr_count_r <= wr_count_r + 1'b1;
      last_loc_r <= mem.waddr;
    end
  end

  // ****************
  // bus write channel
  // ****************
  dprc_wst_t wst_r;
  logic aw_got_r;
  logic w_got_r;
  logic [AXI_AW-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r;

  assign s_axi_awready_o = (wst_r == W_IDLE) && !aw_got_r;
  assign s_axi_wready_o = (wst_r == W_IDLE) && !w_got_r;
  assign s_axi_bvalid_o = (wst_r == W_RESP);
  assign s_axi_bresp_o = bresp_r;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      aw_got_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_got_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr_i;
    end else if (wst_r == W_IDLE && aw_got_r && w_got_r) begin
      aw_got_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      w_got_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_got_r <= 1'b1;
      w_data_r <= s_axi_wdata_i;
      w_strb_r <= s_axi_wstrb_i;
    end else if (wst_r == W_IDLE && aw_got_r && w_got_r) begin
      w_got_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      wst_r <= W_IDLE;
      bresp_r <= RESP_OKAY;
    end else begin
      unique case (wst_r)
        W_IDLE: begin
          if (aw_got_r && w_got_r) begin
            wst_r <= W_RESP;
            bresp_r <= (aw_addr_r == CFG_OFS || aw_addr_r == STAT_OFS) ? RESP_OKAY : RESP_SLVERR;
          end
        end
        W_RESP: begin
          if (s_axi_bready_i) begin
            wst_r <= W_IDLE;
          end
        end
        default: begin
          wst_r <= W_IDLE;
        end
      endcase
    end
  end

  // only the config word is writable; status writes are accepted and dropped
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      cfg_r <= CFG_RST;
    end else if (wst_r == W_IDLE && aw_got_r && w_got_r && aw_addr_r == CFG_OFS
                 && w_strb_r[0]) begin
      cfg_r <= w_data_r[6:0];
    end
  end

  // ****************
  // bus read channel
  // ****************
  dprc_rst_t rst_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  assign s_axi_arready_o = (rst_r == R_IDLE);
  assign s_axi_rvalid_o = (rst_r == R_DATA);
  assign s_axi_rdata_o = rdata_r;
  assign s_axi_rresp_o = rresp_r;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rst_r <= R_IDLE;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else begin
      unique case (rst_r)
        R_IDLE: begin
          if (s_axi_arvalid_i) begin
            rst_r <= R_DATA;
            rresp_r <= RESP_OKAY;
            if (s_axi_araddr_i == CFG_OFS) begin
              rdata_r <= {25'h0000000, cfg_r};
            end else if (s_axi_araddr_i == STAT_OFS) begin
              rdata_r <= {8'h00, last_loc_r, wr_count_r};
            end else begin
              rdata_r <= '0;
              rresp_r <= RESP_SLVERR;
            end
          end
        end
        R_DATA: begin
          if (s_axi_rready_i) begin
            rst_r <= R_IDLE;
          end
        end
        default: begin
          rst_r <= R_IDLE;
        end
      endcase
    end
  end

  // ****************
  // checks
  // ****************
  a_single_one_clock: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    mode == MODE_SINGLE && input_side_clock_i && input_clock_gate_i && output_clock_gate_i
    && rd_en |=> rd_data_r == $past(mem.rdata))
    else $error("single mode read missed its edge");
  a_rdwr_write_edge: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    mode == MODE_RDWR && !input_side_clock_i |-> !mem.we)
    else $error("write taken without write clock");
  a_rdwr_read_edge: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    mode == MODE_RDWR && !output_side_clock_i |=> $stable(rd_data_r))
    else $error("read data moved without read clock");
  a_inout_read_in: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    mode == MODE_INOUT && !input_side_clock_i |=> $stable(rd_data_r))
    else $error("input mode read moved off input clock");
  a_outreg_clocked: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    mode == MODE_INOUT && output_side_clock_i && output_clock_gate_i
    |=> q_out_r == $past(rd_data_r))
    else $error("output register missed output clock");
  a_gate_blocks_read: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !ebs && !read_gate_i |=> $stable(rd_data_r))
    else $error("read taken with gate low");
  a_mask_withheld: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    mem.we && leb |-> mem.wmask == MASK_ALL)
    else $error("lane mask used on logic build");
  a_rom_no_write: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    topo == TOPO_ROM |-> !mem.we)
    else $error("write on read-only topology");
  a_outgate_hold: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !output_clock_gate_i [*2] |=> $stable(q_out_r))
    else $error("output register moved with gate low");
  a_single_read_gate: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    mode == MODE_SINGLE && !output_clock_gate_i |=> $stable(rd_data_r))
    else $error("single mode read moved with output gate low");
  a_ingate_hold: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !input_clock_gate_i && mode != MODE_RDWR |-> !mem.we)
    else $error("write taken with input gate low");
  a_strobe_a_write: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    port_a_sel && in_go && mode != MODE_RDWR && write_strobe_a_i
    |-> mem.we && mem.waddr == location_a_i)
    else $error("port A strobe did not write location A");
  a_bus_answer: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");

  c_rdwr_write: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
    mode == MODE_RDWR && mem.we ##1 rd_go);
  c_outreg_path: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
    oreg_en && rd_go ##[1:4] q_go);
  c_port_a_masked: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
    port_a_sel && mem.we && mem.wmask != MASK_ALL);
endmodule : dprc_top
